//--- asp_pkg.sv
package asp_pkg;

   // ----------------------------------------------------------------
   // taskfile address decode (cs1, da2..da0 within each block)
   // ----------------------------------------------------------------
   localparam logic [2:0] ADDR_FEATURE = 3'h1;
   localparam logic [2:0] ADDR_SECCNT = 3'h2;
   localparam logic [2:0] ADDR_LBALO = 3'h3;
   localparam logic [2:0] ADDR_LBAMID = 3'h4;
   localparam logic [2:0] ADDR_LBAHI = 3'h5;
   localparam logic [2:0] ADDR_DEVICE = 3'h6;
   localparam logic [2:0] ADDR_CMDSTAT = 3'h7;
   localparam logic [2:0] ADDR_DEVCTL = 3'h6;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int DEV_BIT = 4;
   localparam int SRST_BIT = 2;
   localparam int NIEN_BIT = 1;

   // ----------------------------------------------------------------
   // reset values and opcodes
   // ----------------------------------------------------------------
   localparam logic [7:0] DEVICE_RST = 8'h00;
   localparam logic [7:0] DEVCTL_RST = 8'h00;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam logic [7:0] OP_EXEC_DIAG = 8'h90;
   localparam logic [7:0] OP_DEVICE_RESET = 8'h08;

   // ----------------------------------------------------------------
   // strobe tracking
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ASP_IDLE = 2'b00,
      ASP_RD = 2'b01,
      ASP_WR = 2'b10
   } asp_cycle_e;

endpackage : asp_pkg

//--- asp_reg8.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------
// small byte register with masked write and registered read
// ----------------------------------------------------------------
module asp_reg8 #(
   parameter logic [7:0] RESET_VALUE = 8'h00
)
(
   input wire logic clk,
   input wire logic rstN,
   input wire logic wrEn,
   input wire logic [7:0] wrMask,
   input wire logic [7:0] wrData,
   output logic [7:0] value
);

   logic [7:0] valueD;

   always_comb
   begin
      valueD = value;
      if (wrEn)
      begin
         valueD = (value & ~wrMask) | (wrData & wrMask);
      end
   end

   always_ff @(posedge clk or negedge rstN)
   begin
      if (!rstN)
      begin
         value <= RESET_VALUE;
      end
      else
      begin
         value <= valueD;
      end
   end

endmodule : asp_reg8

`default_nettype wire

//--- asp_decode.sv
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// RQ1: proxy Device read: DEV forced one, packet 00h
// RQ2: proxy command stored, only diagnostics acted on
// RQ3: proxy Status read returns zero byte
// RQ4: both chip selects asserted: cycle ignored
// RQ5: sleep without reset: only Device Control write
// RQ6: sleep Device Control write: SRST only, wake
// RQ7: sleep with reset: Device write updates DEV
// RQ8: sleep command: only selected DEVICE RESET
// RQ9: sleep reads ignored, data bus released
// RQ10: sleep: DMARQ kept released
// RQ11: selected when DEV equals own number
// RQ12: no timeout while waiting on host
// RQ13: proxy Device write stored, DEV acted on
// RQ14: proxy Device Control write stored, acted on
// RQ15: host addressing of control and command
module asp_decode
(
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic cs0N,
   input wire logic cs1N,
   input wire logic [2:0] da,
   input wire logic diorN,
   input wire logic diowN,
   input wire logic [7:0] ddIn,
   input wire logic devNumber,
   input wire logic proxyMode,
   input wire logic sleepMode,
   input wire logic resetCmdSupported,
   input wire logic packetSupported,
   input wire logic dmaReqInternal,
   input wire logic [7:0] statusInternal,
   input wire logic [7:0] regRdData,
   output logic [7:0] ddOut,
   output logic ddOe,
   output logic dmarq,
   output logic [7:0] deviceReg,
   output logic [7:0] devCtlReg,
   output logic [7:0] commandReg,
   output logic cmdStrobe,
   output logic srstLevel,
   output logic intDisable,
   output logic wakeStrobe,
   output logic selected,
   output logic [2:0] taskWrStrobeAddr,
   output logic taskWrStrobe
);

   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   logic [1:0] rstSync_q;
   logic rstN;

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rstSync_q <= 2'h0;
      end
      else
      begin
         rstSync_q <= {rstSync_q[0], 1'b1};
      end
   end

   assign rstN = rstSync_q[1];

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   function automatic logic cmdBlk(input logic c0N, input logic c1N, input logic [2:0] a,
      input logic [2:0] want);
      cmdBlk = !c0N && c1N && (a == want);
   endfunction : cmdBlk

   function automatic logic ctlBlk(input logic c0N, input logic c1N, input logic [2:0] a,
      input logic [2:0] want);
      ctlBlk = c0N && !c1N && (a == want);
   endfunction : ctlBlk

   logic bothCs;
   logic hitDevice;
   logic hitCmd;
   logic hitDevCtl;
   logic selNow;

   assign bothCs = !cs0N && !cs1N; // RQ4
   assign hitDevice = cmdBlk(cs0N, cs1N, da, asp_pkg::ADDR_DEVICE); // RQ15
   assign hitCmd = cmdBlk(cs0N, cs1N, da, asp_pkg::ADDR_CMDSTAT);
   assign hitDevCtl = ctlBlk(cs0N, cs1N, da, asp_pkg::ADDR_DEVCTL);
   assign selNow = deviceReg[asp_pkg::DEV_BIT] == devNumber; // RQ11

   // ----------------------------------------------------------------
   // strobe edge tracking, no timeout on host
   // ----------------------------------------------------------------
   asp_pkg::asp_cycle_e cyc_q;
   asp_pkg::asp_cycle_e cyc_d;
   logic wrEdge;
   logic rdActive;

   always_comb
   begin
      cyc_d = asp_pkg::ASP_IDLE;
      if (!diowN)
      begin
         cyc_d = asp_pkg::ASP_WR;
      end
      else if (!diorN)
      begin
         cyc_d = asp_pkg::ASP_RD;
      end
   end

   always_ff @(posedge sys_clk or negedge rstN)
   begin
      if (!rstN)
      begin
         cyc_q <= asp_pkg::ASP_IDLE;
      end
      else
      begin
         cyc_q <= cyc_d; // RQ12
      end
   end

   // write taken when strobe rises, data sampled the cycle before
   logic [7:0] wrData_q;
   logic [2:0] wrDa_q;
   logic wrCs0N_q;
   logic wrCs1N_q;

   always_ff @(posedge sys_clk or negedge rstN)
   begin
      if (!rstN)
      begin
         wrData_q <= 8'h00;
         wrDa_q <= 3'h0;
         wrCs0N_q <= 1'b1;
         wrCs1N_q <= 1'b1;
      end
      else if (!diowN)
      begin
         wrData_q <= ddIn;
         wrDa_q <= da;
         wrCs0N_q <= cs0N;
         wrCs1N_q <= cs1N;
      end
   end

   assign wrEdge = (cyc_q == asp_pkg::ASP_WR) && diowN;
   assign rdActive = (cyc_d == asp_pkg::ASP_RD) && !bothCs && !(cs0N && cs1N); // RQ4

   // ----------------------------------------------------------------
   // write qualification
   // ----------------------------------------------------------------
   logic wBoth;
   logic wDevice;
   logic wCmd;
   logic wDevCtl;
   logic devWrEn;
   logic [7:0] devWrMask;
   logic ctlWrEn;
   logic [7:0] ctlWrMask;
   logic cmdWrEn;
   logic cmdAct;
   logic otherWr;

   assign wBoth = !wrCs0N_q && !wrCs1N_q;
   assign wDevice = wrEdge && !wBoth && cmdBlk(wrCs0N_q, wrCs1N_q, wrDa_q, asp_pkg::ADDR_DEVICE);
   assign wCmd = wrEdge && !wBoth && cmdBlk(wrCs0N_q, wrCs1N_q, wrDa_q, asp_pkg::ADDR_CMDSTAT);
   assign wDevCtl = wrEdge && !wBoth && ctlBlk(wrCs0N_q, wrCs1N_q, wrDa_q, asp_pkg::ADDR_DEVCTL);

   always_comb
   begin
      devWrEn = 1'b0;
      devWrMask = 8'hFF;
      ctlWrEn = 1'b0;
      ctlWrMask = 8'hFF;
      cmdWrEn = 1'b0;
      cmdAct = 1'b0;
      otherWr = 1'b0;
      if (sleepMode)
      begin
         ctlWrEn = wDevCtl; // RQ5
         ctlWrMask = 8'h00;
         ctlWrMask[asp_pkg::SRST_BIT] = 1'b1; // RQ6
         if (resetCmdSupported)
         begin
            devWrEn = wDevice; // RQ7
            devWrMask = 8'h00;
            devWrMask[asp_pkg::DEV_BIT] = 1'b1;
            cmdWrEn = wCmd && selNow && (wrData_q == asp_pkg::OP_DEVICE_RESET); // RQ8
            cmdAct = cmdWrEn;
         end
      end
      else
      begin
         devWrEn = wDevice; // RQ13
         ctlWrEn = wDevCtl; // RQ14
         cmdWrEn = wCmd; // RQ2
         cmdAct = wCmd && (!proxyMode || wrData_q == asp_pkg::OP_EXEC_DIAG); // RQ2
         otherWr = wrEdge && !wBoth && !wDevice && !wCmd && !wDevCtl;
      end
   end

   // ----------------------------------------------------------------
   // taskfile bytes
   // ----------------------------------------------------------------
   asp_reg8 #(.RESET_VALUE(asp_pkg::DEVICE_RST)) uDevice (
      .clk(sys_clk),
      .rstN(rstN),
      .wrEn(devWrEn),
      .wrMask(devWrMask),
      .wrData(wrData_q),
      .value(deviceReg)
   );

   asp_reg8 #(.RESET_VALUE(asp_pkg::DEVCTL_RST)) uDevCtl (
      .clk(sys_clk),
      .rstN(rstN),
      .wrEn(ctlWrEn),
      .wrMask(ctlWrMask),
      .wrData(wrData_q),
      .value(devCtlReg)
   );

   asp_reg8 #(.RESET_VALUE(8'h00)) uCommand (
      .clk(sys_clk),
      .rstN(rstN),
      .wrEn(cmdWrEn),
      .wrMask(8'hFF),
      .wrData(wrData_q),
      .value(commandReg)
   );

   // ----------------------------------------------------------------
   // event and level outputs
   // ----------------------------------------------------------------
   logic cmdStrobe_d;
   logic wakeStrobe_d;
   logic taskWrStrobe_d;

   always_comb
   begin
      cmdStrobe_d = cmdAct;
      wakeStrobe_d = sleepMode && wDevCtl && wrData_q[asp_pkg::SRST_BIT]; // RQ6
      taskWrStrobe_d = otherWr;
   end

   always_ff @(posedge sys_clk or negedge rstN)
   begin
      if (!rstN)
      begin
         cmdStrobe <= 1'b0;
         wakeStrobe <= 1'b0;
         taskWrStrobe <= 1'b0;
         taskWrStrobeAddr <= 3'h0;
         srstLevel <= 1'b0;
         intDisable <= 1'b0;
         selected <= 1'b0;
      end
      else
      begin
         cmdStrobe <= cmdStrobe_d;
         wakeStrobe <= wakeStrobe_d;
         taskWrStrobe <= taskWrStrobe_d;
         taskWrStrobeAddr <= wrDa_q;
         srstLevel <= devCtlReg[asp_pkg::SRST_BIT]; // RQ14
         intDisable <= devCtlReg[asp_pkg::NIEN_BIT]; // RQ14
         selected <= selNow; // RQ11
      end
   end

   // ----------------------------------------------------------------
   // read data and bus drive
   // ----------------------------------------------------------------
   logic [7:0] ddOut_d;
   logic ddOe_d;
   logic dmarq_d;

   always_comb
   begin
      ddOut_d = regRdData;
      ddOe_d = rdActive && !sleepMode; // RQ9
      dmarq_d = dmaReqInternal && !sleepMode; // RQ10
      if (hitDevice)
      begin
         ddOut_d = deviceReg;
         if (proxyMode)
         begin
            ddOut_d[asp_pkg::DEV_BIT] = 1'b1; // RQ1
            if (packetSupported)
            begin
               ddOut_d = asp_pkg::ZERO_BYTE; // RQ1
            end
         end
      end
      else if (hitCmd)
      begin
         ddOut_d = proxyMode ? asp_pkg::ZERO_BYTE : statusInternal; // RQ3
      end
   end

   always_ff @(posedge sys_clk or negedge rstN)
   begin
      if (!rstN)
      begin
         ddOut <= 8'h00;
         ddOe <= 1'b0;
         dmarq <= 1'b0;
      end
      else
      begin
         ddOut <= ddOut_d;
         ddOe <= ddOe_d;
         dmarq <= dmarq_d;
      end
   end

endmodule : asp_decode

`default_nettype wire

//--- asp_decode_chk.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------
// port checks for the taskfile decode
// ----------------------------------------------------------------
module asp_decode_chk
(
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic cs0N,
   input wire logic cs1N,
   input wire logic [2:0] da,
   input wire logic diorN,
   input wire logic diowN,
   input wire logic [7:0] ddIn,
   input wire logic proxyMode,
   input wire logic sleepMode,
   input wire logic resetCmdSupported,
   input wire logic packetSupported,
   input wire logic [7:0] ddOut,
   input wire logic ddOe,
   input wire logic dmarq,
   input wire logic [7:0] deviceReg,
   input wire logic [7:0] devCtlReg,
   input wire logic [7:0] commandReg,
   input wire logic cmdStrobe,
   input wire logic wakeStrobe,
   input wire logic selected
);
   wire logic aDev = !cs0N && cs1N && da == 3'h6;
   wire logic aCmd = !cs0N && cs1N && da == 3'h7;
   wire logic aCtl = cs0N && !cs1N && da == 3'h6;
   wire logic devBit = ddIn[4];
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);

   AST_SLEEP_DMARQ: assert property ($past(sleepMode) |-> !dmarq)
      else $error("dmarq raised in sleep");
   AST_SLEEP_READ: assert property ($past(sleepMode) |-> !ddOe)
      else $error("data bus driven in sleep");
   AST_BOTH_CS_READ: assert property (!cs0N && !cs1N && !diorN |=> !ddOe)
      else $error("data bus driven with both selects");
   AST_PROXY_STATUS: assert property (proxyMode && !sleepMode && aCmd && !diorN
      |=> ddOe && ddOut == 8'h00) else $error("proxy status not zero");
   AST_PROXY_DEV_READ: assert property (proxyMode && !sleepMode && aDev && !diorN
      |=> ddOut == (packetSupported ? 8'h00 : (deviceReg | 8'h10)))
      else $error("proxy device read wrong");
   AST_PROXY_CMD: assert property ($rose(diowN) && proxyMode && !sleepMode && $past(aCmd)
      |=> commandReg == $past(ddIn, 2) && cmdStrobe == (commandReg == 8'h90))
      else $error("proxy command handling wrong");
   AST_BOTH_CS_WRITE: assert property ($rose(diowN) && !$past(cs0N) && !$past(cs1N)
      |=> $stable(commandReg) && $stable(deviceReg) && $stable(devCtlReg) && !cmdStrobe)
      else $error("write with both selects taken");
   AST_SLEEP_CTL: assert property ($rose(diowN) && sleepMode && $past(aCtl)
      |=> (devCtlReg & 8'hFB) == ($past(devCtlReg) & 8'hFB) && wakeStrobe == devCtlReg[2]
      && devCtlReg[2] == $past(ddIn[2], 2))
      else $error("sleep control write wrong");
   AST_SLEEP_DEV: assert property ($rose(diowN) && sleepMode && $past(aDev)
      |=> (deviceReg & 8'hEF) == ($past(deviceReg) & 8'hEF)
      && deviceReg[4] == (resetCmdSupported ? $past(devBit, 2) : $past(deviceReg[4])))
      else $error("sleep device write wrong");
   AST_SLEEP_CMD: assert property ($rose(diowN) && sleepMode && $past(aCmd)
      |=> cmdStrobe == (resetCmdSupported && $past(selected) && $past(ddIn, 2) == 8'h08))
      else $error("sleep command filter wrong");
endmodule : asp_decode_chk

bind asp_decode asp_decode_chk i_chk (.*);

`default_nettype wire

//--- asp_host_model.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------
// host adapter: one strobe cycle per call
// ----------------------------------------------------------------
module asp_host_model
(
   input wire logic sys_clk,
   output logic cs0N,
   output logic cs1N,
   output logic [2:0] da,
   output logic diorN,
   output logic diowN,
   output logic [7:0] ddIn,
   input wire logic [7:0] ddOut,
   input wire logic ddOe
);
   initial
   begin
      cs0N = 1'b1;
      cs1N = 1'b1;
      da = 3'h0;
      diorN = 1'b1;
      diowN = 1'b1;
      ddIn = 8'h5A;
   end

   // caller picks selects and address per register
   task automatic wr(input logic c0, input logic c1, input logic [2:0] a, input logic [7:0] d,
      input int hold);
      @(negedge sys_clk);
      cs0N = c0;
      cs1N = c1;
      da = a;
      ddIn = d;
      diowN = 1'b0;
      repeat (hold) @(negedge sys_clk);
      diowN = 1'b1;
      @(negedge sys_clk);
      cs0N = 1'b1;
      cs1N = 1'b1;
      ddIn = ~d;
   endtask : wr

   task automatic rd(input logic c0, input logic c1, input logic [2:0] a,
      output logic [7:0] d, output logic oe);
      @(negedge sys_clk);
      cs0N = c0;
      cs1N = c1;
      da = a;
      diorN = 1'b0;
      @(negedge sys_clk);
      d = ddOut;
      oe = ddOe;
      diorN = 1'b1;
      @(negedge sys_clk);
      cs0N = 1'b1;
      cs1N = 1'b1;
   endtask : rd
endmodule : asp_host_model

`default_nettype wire

//--- tb.sv
`timescale 1ns/1ns
`default_nettype none

module tb;
   logic sys_clk, reset_n, cs0N, cs1N, diorN, diowN, devNumber, proxyMode, sleepMode;
   logic resetCmdSupported, packetSupported, dmaReqInternal, ddOe, dmarq, cmdStrobe;
   logic srstLevel, intDisable, wakeStrobe, selected, taskWrStrobe, oe;
   logic [2:0] da, taskWrStrobeAddr;
   logic [7:0] ddIn, ddOut, deviceReg, devCtlReg, commandReg, d;
   int error_cnt = 0;
   int checked = 0;
   int cmdCnt = 0;
   int wakeCnt = 0;
   int taskCnt = 0;
   logic [2:0] taskAddr;
   int n;

   asp_decode i_dut (.statusInternal(8'h5A), .regRdData(8'hC3), .*);
   asp_host_model i_host (.*);

   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   always @(negedge sys_clk)
   begin
      if (cmdStrobe === 1'b1) cmdCnt++;
      if (wakeStrobe === 1'b1) wakeCnt++;
      if (taskWrStrobe === 1'b1)
      begin
         taskCnt++;
         taskAddr = taskWrStrobeAddr;
      end
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic w(input logic c0, input logic c1, input logic [2:0] a, input logic [7:0] v);
      n = cmdCnt;
      i_host.wr(c0, c1, a, v, 1);
      repeat (4) @(negedge sys_clk);
   endtask : w

   task automatic print_verdict;
      $display("checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : print_verdict

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_proxy;
      @(negedge sys_clk);
      proxyMode = 1'b1;
      w(0, 1, 3'h6, 8'hA0);
      chk(deviceReg, 8'hA0);
      chk(8'(selected), 8'h01);
      i_host.rd(0, 1, 3'h6, d, oe);
      chk(d, 8'hB0);
      packetSupported = 1'b1;
      i_host.rd(0, 1, 3'h6, d, oe);
      chk(d, 8'h00);
      i_host.rd(0, 1, 3'h7, d, oe);
      chk(d, 8'h00);
      chk(8'(oe), 8'h01);
      w(0, 1, 3'h7, 8'h20);
      chk(8'(cmdCnt - n), 8'h00);
      chk(commandReg, 8'h20);
      w(0, 1, 3'h7, 8'h90);
      chk(8'(cmdCnt - n), 8'h01);
      w(1, 0, 3'h6, 8'h06);
      chk({6'h00, srstLevel, intDisable}, 8'h03);
      w(1, 0, 3'h6, 8'h00);
   endtask : t_proxy

   task automatic t_both;
      w(0, 0, 3'h7, 8'h08);
      chk(8'(cmdCnt - n), 8'h00);
      chk(commandReg, 8'h90);
      i_host.rd(0, 0, 3'h7, d, oe);
      chk(8'(oe), 8'h00);
      n = cmdCnt;
      i_host.wr(0, 1, 3'h7, 8'h90, 300);
      repeat (4) @(negedge sys_clk);
      chk(8'(cmdCnt - n), 8'h01);
      w(0, 1, 3'h2, 8'h11);
      chk(8'(taskCnt), 8'h01);
      chk({5'h00, taskAddr}, 8'h02);
      chk(commandReg, 8'h90);
   endtask : t_both

   task automatic t_sleep;
      @(negedge sys_clk);
      proxyMode = 1'b0;
      dmaReqInternal = 1'b1;
      repeat (2) @(negedge sys_clk);
      chk(8'(dmarq), 8'h01);
      sleepMode = 1'b1;
      w(0, 1, 3'h6, 8'hF0);
      chk(deviceReg, 8'hA0);
      w(0, 1, 3'h7, 8'h08);
      chk(8'(cmdCnt - n), 8'h00);
      w(1, 0, 3'h6, 8'hFB);
      chk(devCtlReg, 8'h00);
      chk(8'(wakeCnt), 8'h00);
      w(1, 0, 3'h6, 8'h04);
      chk(devCtlReg, 8'h04);
      chk(8'(wakeCnt), 8'h01);
      i_host.rd(0, 1, 3'h7, d, oe);
      chk(8'(oe), 8'h00);
      i_host.rd(1, 0, 3'h6, d, oe);
      chk(8'(oe), 8'h00);
      chk(8'(dmarq), 8'h00);
      resetCmdSupported = 1'b1;
      w(0, 1, 3'h6, 8'h5F);
      chk(deviceReg, 8'hB0);
      chk(8'(selected), 8'h00);
      w(0, 1, 3'h7, 8'h08);
      chk(8'(cmdCnt - n), 8'h00);
      w(0, 1, 3'h6, 8'h00);
      w(0, 1, 3'h7, 8'h90);
      chk(8'(cmdCnt - n), 8'h00);
      w(0, 1, 3'h7, 8'h08);
      chk(8'(cmdCnt - n), 8'h01);
   endtask : t_sleep

   initial
   begin
      reset_n = 1'b0;
      devNumber = 1'b0;
      proxyMode = 1'b0;
      sleepMode = 1'b0;
      resetCmdSupported = 1'b0;
      packetSupported = 1'b0;
      dmaReqInternal = 1'b0;
      repeat (4) @(negedge sys_clk);
      reset_n = 1'b1;
      repeat (4) @(negedge sys_clk);
      t_proxy;
      t_both;
      t_sleep;
      print_verdict;
   end

   initial
   begin
      #100000;
      error_cnt++;
      print_verdict;
   end
endmodule : tb

`default_nettype wire
